// file: pll_reconfig_pkg.sv
package pll_reconfig_pkg;
	// one counter scan segment, low count shifted in first
	localparam int SEG_W    = 18;
	localparam int CNT_W    = 8;
	localparam int HALF_W   = CNT_W + 1;
	localparam int LO_LSB   = 0;
	localparam int HI_LSB   = 8;
	localparam int ODD_BIT  = 16;
	localparam int SKIP_BIT = 17;
	localparam logic [SEG_W-1:0]  SEG_RESET = 18'h20000;
	localparam logic [HALF_W-1:0] HALF_ONE  = 9'h001;

	// tail after the counter segments, loop-filter resistor msb last
	localparam int TAIL_W     = 18;
	localparam int CP_LSB     = 0;
	localparam int CP_W       = 3;
	localparam int K_LSB      = 3;
	localparam int UNUSED_LSB = 4;
	localparam int UNUSED_W   = 7;
	localparam int LFC_LSB    = 11;
	localparam int LFC_W      = 2;
	localparam int LFR_LSB    = 13;
	localparam int LFR_W      = 5;
	localparam int MISC_W     = 2 * SEG_W + TAIL_W;

	localparam int NC_LARGE = 10;
	localparam int NC_SMALL = 7;

	function automatic int chain_len(input int nc);
		return (nc + 2) * SEG_W + TAIL_W;
	endfunction

	// length in half vco cycles of one output phase
	function automatic logic [HALF_W-1:0] half_len(input logic [CNT_W-1:0] c,
		input logic odd, input logic hi);
		logic [HALF_W-1:0] h;
		h = {c, 1'b0};
		if (hi) begin
			h = h - {8'h00, odd};
		end else begin
			h = h + {8'h00, odd};
		end
		if (h == 9'h000) begin
			h = HALF_ONE;
		end
		return h;
	endfunction

	// device pin sampling order
	localparam int NP    = 5;
	localparam int P_CLK = 0;
	localparam int P_EN  = 1;
	localparam int P_DAT = 2;
	localparam int P_APL = 3;
	localparam int P_CLR = 4;
	localparam logic [2:0] PEND_MIN_CYC = 3'h4;

	// timing
	localparam int PCLK_PERIOD_NS     = 40;
	localparam int SCAN_FMAX_MHZ      = 100;
	localparam int SCAN_MIN_PERIOD_NS = 1000 / SCAN_FMAX_MHZ;
	localparam int SCAN_MIN_HALF_RAW  = (SCAN_MIN_PERIOD_NS / 2 + PCLK_PERIOD_NS - 1)
		/ PCLK_PERIOD_NS;
	localparam int SCAN_MIN_HALF_CYC  = (SCAN_MIN_HALF_RAW > 1) ? SCAN_MIN_HALF_RAW : 1;
	localparam int SCAN_HALF_DEF      = 12;
	localparam int CLEAR_CYC          = 8;

	// controller registers
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IMG  = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_RB   = 8'h80;
	localparam int CTRL_GO      = 0;
	localparam int CTRL_AUTOCLR = 1;
	localparam int ST_BUSY      = 0;
	localparam int ST_DONE      = 1;
	localparam int ST_PEND      = 2;

	typedef enum logic [8:0] {
		S_IDLE  = 9'h001,
		S_ENA   = 9'h002,
		S_SHIFT = 9'h004,
		S_STOP  = 9'h008,
		S_APPLY = 9'h010,
		S_HOLD  = 9'h020,
		S_WT_HI = 9'h040,
		S_WT_LO = 9'h080,
		S_CLR   = 9'h100
	} ctl_state_t;
endpackage

// file: scan_if.sv
`timescale 1ns/1ps
interface scan_if;
	logic scan_clk;
	logic shift_enable;
	logic serial_config_in;
	logic apply_settings;
	logic pll_async_clear;
	logic reprogram_pending;
	logic serial_config_out;

	modport dev (
		input  scan_clk,
		input  shift_enable,
		input  serial_config_in,
		input  apply_settings,
		input  pll_async_clear,
		output reprogram_pending,
		output serial_config_out
	);

	modport ctl (
		output scan_clk,
		output shift_enable,
		output serial_config_in,
		output apply_settings,
		output pll_async_clear,
		input  reprogram_pending,
		input  serial_config_out
	);
endinterface

// file: pll_scan_chain_reconfig.sv
`timescale 1ns/1ps
// Functional notes
// (RL1) each counter loads at its own boundary
// (RL2) shift only while shift enable high
// (RL3) apply copies chain into working settings
// (RL4) pending high until all counters updated
// (RL5) chain contents shift out serially
// (RL6) controller enables one cycle before data
// (RL7) capture begins second rising edge after enable
// (RL8) controller stops after 234 or 180 bits
// (RL9) controller pulses apply for one cycle
// (RL10) controller clears pll after divider changes
// (RL11) sequence repeatable without limit
// (RL12) controller reapplies phase after frequency change; this controller issues no phase step
// (RL13) 8-bit high and low counts
// (RL14) skip bit divides by one
// (RL15) no odd bit: fall on vco rise
// (RL16) odd bit: fall on vco fall
// (RL17) ten or seven post-scale counters
// (RL18) 18 bits per counter segment
// (RL19) large: top counter low lsb first
// (RL20) small: top counter low lsb first
// (RL21) loop-filter msb shifted last
// (RL22) tail holds cp, k, unused, filter
// (RL23) controller scan clock at most 100 MHz
module pll_scan_chain_reconfig
	import pll_reconfig_pkg::*;
#(
	parameter int NUM_CNT = NC_LARGE
) (
	// system
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// link
	scan_if.dev                              lnk,
	// divided outputs
	output logic [NUM_CNT-1:0]            clk_out,
	// working configuration
	output logic [NUM_CNT-1:0][SEG_W-1:0] post_cfg,
	output logic [SEG_W-1:0]              pre_cfg,
	output logic [SEG_W-1:0]              fb_cfg,
	output logic [CP_W-1:0]               cp_current,
	output logic                          post_vco_div,
	output logic [LFC_W-1:0]              lf_cap,
	output logic [LFR_W-1:0]              lf_res,
	output logic                          pll_in_reset
);
	localparam int CHAIN_LEN = chain_len(NUM_CNT);
	localparam int CNT_BITS  = NUM_CNT * SEG_W;

	logic [NP-1:0]        s1_r;
	logic [NP-1:0]        s2_r;
	logic [NP-1:0]        s3_r;
	logic [NP-1:0]        set_r;
	logic                 clk_prev_r;
	logic                 armed_r;
	logic                 pend_r;
	logic                 in_reset_r;
	logic [2:0]           pend_cnt_r;
	logic [CHAIN_LEN-1:0] chain_r;
	logic [CNT_BITS-1:0]  staged_r;
	logic [MISC_W-1:0]    misc_r;
	logic [NUM_CNT-1:0]   req_v;

	wire [NP-1:0] pins = {lnk.pll_async_clear, lnk.apply_settings, lnk.serial_config_in,
		lnk.shift_enable, lnk.scan_clk};

	wire scan_rise = set_r[P_CLK] & ~clk_prev_r;
	wire en_s      = set_r[P_EN];
	wire clr_s     = set_r[P_CLR];
	// (RL7) second rising edge
	wire shift_evt = scan_rise & en_s & armed_r;
	// (RL3) apply on scan edge
	wire apply_evt = scan_rise & set_r[P_APL];

	wire [TAIL_W-1:0] tail = misc_r[2*SEG_W +: TAIL_W];

	// a level only moves once the second and third stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r       <= '0;
			s2_r       <= '0;
			s3_r       <= '0;
			set_r      <= '0;
			clk_prev_r <= 1'b0;
		end else begin
			s1_r       <= pins;
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			set_r      <= (s2_r & s3_r) | (set_r & (s2_r | s3_r));
			clk_prev_r <= set_r[P_CLK];
		end
	end

	// (RL2) gated shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 1'b0;
		end else if (scan_rise) begin
			armed_r <= en_s;
		end
	end

	// (RL19) first bit ends at index 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_r <= '0;
		end else if (shift_evt) begin
			chain_r <= {set_r[P_DAT], chain_r[CHAIN_LEN-1:1]};
		end
	end

	// (RL3) capture whole chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			staged_r <= '0;
			misc_r   <= '0;
		end else if (apply_evt) begin
			staged_r <= chain_r[CNT_BITS-1:0];
			misc_r   <= chain_r[CHAIN_LEN-1:CNT_BITS];
		end
	end

	// minimum width keeps the pulse visible through a three-stage sampler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_cnt_r <= 3'h0;
			pend_r     <= 1'b0;
			in_reset_r <= 1'b0;
		end else begin
			if (apply_evt) begin
				pend_cnt_r <= PEND_MIN_CYC;
			end else if (pend_cnt_r != 3'h0) begin
				pend_cnt_r <= pend_cnt_r - 3'h1;
			end
			// (RL4) pending until counters loaded
			pend_r     <= apply_evt | (|req_v) | (pend_cnt_r != 3'h0);
			in_reset_r <= clr_s;
		end
	end

	// pclk is one half vco cycle; counts run in half-cycle steps
	// (RL17) one counter per output
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		// (RL20) highest counter sits first
		localparam int BASE = (NUM_CNT - 1 - i) * SEG_W;
		logic [SEG_W-1:0]  cfg_r;
		logic [HALF_W-1:0] cnt_r;
		logic              out_r;
		logic              req_r;

		// (RL18) one 18-bit segment each
		wire [SEG_W-1:0] seg_new = staged_r[BASE +: SEG_W];
		wire             last    = cnt_r <= HALF_ONE;
		wire             start   = last & ~out_r;
		// (RL1) load only at own period boundary
		wire [SEG_W-1:0] use_cfg = (start & req_r) ? seg_new : cfg_r;
		// (RL14) skip gives divide by one
		wire [HALF_W-1:0] hi_len = use_cfg[SKIP_BIT] ? '0 :
			half_len(use_cfg[HI_LSB +: CNT_W], use_cfg[ODD_BIT], 1'b1);
		// (RL16) odd moves the fall half a cycle
		wire [HALF_W-1:0] lo_len = cfg_r[SKIP_BIT] ? '0 :
			half_len(cfg_r[LO_LSB +: CNT_W], cfg_r[ODD_BIT], 1'b0);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_r <= SEG_RESET;
				cnt_r <= '0;
				out_r <= 1'b0;
				req_r <= 1'b0;
			end else begin
				// new request wins over the load that clears it
				req_r <= apply_evt | (req_r & ~start);
				if (start) begin
					cfg_r <= use_cfg;
				end
				if (clr_s) begin
					out_r <= 1'b0;
					cnt_r <= '0;
				end else if (start) begin
					out_r <= 1'b1;
					cnt_r <= hi_len;
				end else if (last) begin
					// (RL15) even count: fall on vco rise
					out_r <= 1'b0;
					cnt_r <= lo_len;
				end else begin
					// (RL13) high and low counts
					cnt_r <= cnt_r - HALF_ONE;
				end
			end
		end

		assign clk_out[i]  = out_r;
		assign post_cfg[i] = cfg_r;
		assign req_v[i]    = req_r;
	end

	// (RL5) readback of oldest bit
	assign lnk.serial_config_out = chain_r[0];
	assign lnk.reprogram_pending = pend_r;

	assign pre_cfg      = misc_r[0 +: SEG_W];
	assign fb_cfg       = misc_r[SEG_W +: SEG_W];
	// (RL22) tail fields
	assign cp_current   = tail[CP_LSB +: CP_W];
	assign post_vco_div = tail[K_LSB];
	assign lf_cap       = tail[LFC_LSB +: LFC_W];
	// (RL21) resistor msb is the top chain bit
	assign lf_res       = tail[LFR_LSB +: LFR_W];
	assign pll_in_reset = in_reset_r;
endmodule

// file: scan_reconfig_ctl.sv
`timescale 1ns/1ps
module scan_reconfig_ctl
	import pll_reconfig_pkg::*;
#(
	parameter int NUM_CNT   = NC_LARGE,
	parameter int SCAN_HALF = SCAN_HALF_DEF
) (
	// system
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// link
	scan_if.ctl                    lnk
);
	localparam int CHAIN_LEN = chain_len(NUM_CNT);
	localparam int WORDS     = (CHAIN_LEN + 31) / 32;
	localparam int IDX_W     = $clog2(CHAIN_LEN);
	// (RL23) never faster than the scan limit
	localparam int HALF      = (SCAN_HALF > SCAN_MIN_HALF_CYC) ? SCAN_HALF : SCAN_MIN_HALF_CYC;
	localparam int DIV_W     = $clog2(HALF + 1);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CHAIN_LEN - 1);
	localparam logic [DIV_W-1:0] DIV_TOP  = DIV_W'(HALF - 1);
	localparam logic [3:0]       CLR_TOP  = 4'(CLEAR_CYC - 1);

	ctl_state_t       state_r;
	logic [DIV_W-1:0] div_r;
	logic [IDX_W-1:0] idx_r;
	logic [3:0]       clr_cnt_r;
	logic             scan_clk_r;
	logic             en_r;
	logic             dat_r;
	logic             apl_r;
	logic             clr_r;
	logic             go_r;
	logic             autoclr_r;
	logic             done_r;
	logic [31:0]      img_r [WORDS];
	logic [31:0]      rb_r [WORDS];
	logic [1:0]       s1_r;
	logic [1:0]       s2_r;
	logic [1:0]       s3_r;
	logic [1:0]       set_r;
	logic [31:0]      prdata_r;
	logic             pready_r;
	logic             pslverr_r;

	wire tick   = div_r == DIV_TOP;
	wire rise   = tick & ~scan_clk_r;
	wire fall   = tick & scan_clk_r;
	wire pend_s = set_r[0];
	wire so_s   = set_r[1];
	wire busy   = state_r != S_IDLE;
	wire start  = (state_r == S_IDLE) & go_r & fall;

	wire [IDX_W-1:0] nidx    = idx_r + 1'b1;
	wire             cur_bit = img_r[idx_r[IDX_W-1:5]][idx_r[4:0]];
	wire             nxt_bit = img_r[nidx[IDX_W-1:5]][nidx[4:0]];

	wire       setup    = psel & ~penable;
	wire       wr_acc   = psel & penable & pready_r & pwrite;
	wire [2:0] widx     = paddr[4:2];
	wire       aligned  = paddr[1:0] == 2'h0;
	wire       sel_ctrl = paddr == OFF_CTRL;
	wire       sel_stat = paddr == OFF_STAT;
	wire       in_img   = aligned && paddr >= OFF_IMG && paddr < OFF_IMG + ADDR_W'(4 * WORDS);
	wire       in_rb    = aligned && paddr >= OFF_RB && paddr < OFF_RB + ADDR_W'(4 * WORDS);
	wire       mapped   = sel_ctrl | sel_stat | in_img | in_rb;

	wire [31:0] ctrl_word = (32'(go_r) << CTRL_GO) | (32'(autoclr_r) << CTRL_AUTOCLR);
	wire [31:0] stat_word = (32'(busy) << ST_BUSY) | (32'(done_r) << ST_DONE)
		| (32'(pend_s) << ST_PEND);
	wire [31:0] rd_word   = sel_ctrl ? ctrl_word : sel_stat ? stat_word :
		in_img ? img_r[widx] : in_rb ? rb_r[widx] : 32'h0;

	wire done_evt = ((state_r == S_WT_LO) & ~pend_s & ~autoclr_r)
		| ((state_r == S_CLR) & (clr_cnt_r == 4'h0));

	// no wait state: answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~mapped;
			if (setup & ~pwrite) begin
				prdata_r <= rd_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_r      <= 1'b0;
			autoclr_r <= 1'b0;
			done_r    <= 1'b0;
		end else begin
			go_r   <= (go_r & ~start) | (wr_acc & sel_ctrl & pwdata[CTRL_GO] & ~busy);
			done_r <= done_evt | (done_r & ~start);
			if (wr_acc & sel_ctrl) begin
				autoclr_r <= pwdata[CTRL_AUTOCLR];
			end
		end
	end

	// image writes are ignored during a transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < WORDS; k++) begin
				img_r[k] <= 32'h0;
			end
		end else if (wr_acc & in_img & ~busy) begin
			img_r[widx] <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r  <= 2'h0;
			s2_r  <= 2'h0;
			s3_r  <= 2'h0;
			set_r <= 2'h0;
		end else begin
			s1_r  <= {lnk.serial_config_out, lnk.reprogram_pending};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			set_r <= (s2_r & s3_r) | (set_r & (s2_r | s3_r));
		end
	end

	// free-running scan clock divided from pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r      <= '0;
			scan_clk_r <= 1'b0;
		end else begin
			div_r      <= tick ? '0 : div_r + 1'b1;
			scan_clk_r <= scan_clk_r ^ tick;
		end
	end

	// enable, data and apply only change on falling scan edges; the clear follows pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= S_IDLE;
			idx_r     <= '0;
			en_r      <= 1'b0;
			dat_r     <= 1'b0;
			apl_r     <= 1'b0;
			clr_r     <= 1'b0;
			clr_cnt_r <= 4'h0;
			for (int k = 0; k < WORDS; k++) begin
				rb_r[k] <= 32'h0;
			end
		end else begin
			case (state_r)
				S_IDLE: begin
					idx_r <= '0;
					// (RL11) every go runs a full pass
					if (start) begin
						en_r    <= 1'b1;
						state_r <= S_ENA;
					end
				end
				S_ENA: begin
					// (RL6) enable a full scan cycle ahead
					if (fall) begin
						dat_r      <= cur_bit;
						rb_r[0][0] <= so_s;
						state_r    <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					// (RL8) stop after the last bit
					if (rise && idx_r == LAST_IDX) begin
						state_r <= S_STOP;
					end else if (fall) begin
						rb_r[nidx[IDX_W-1:5]][nidx[4:0]] <= so_s;
						idx_r <= nidx;
						dat_r <= nxt_bit;
					end
				end
				S_STOP: begin
					if (fall) begin
						en_r    <= 1'b0;
						dat_r   <= 1'b0;
						state_r <= S_APPLY;
					end
				end
				S_APPLY: begin
					// (RL9) apply spans one scan cycle
					if (fall) begin
						apl_r   <= 1'b1;
						state_r <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (fall) begin
						apl_r   <= 1'b0;
						state_r <= S_WT_HI;
					end
				end
				S_WT_HI: begin
					if (pend_s) begin
						state_r <= S_WT_LO;
					end
				end
				S_WT_LO: begin
					// (RL10) optional pll clear after update
					if (!pend_s) begin
						clr_r     <= autoclr_r;
						clr_cnt_r <= CLR_TOP;
						state_r   <= autoclr_r ? S_CLR : S_IDLE;
					end
				end
				S_CLR: begin
					if (clr_cnt_r == 4'h0) begin
						clr_r   <= 1'b0;
						state_r <= S_IDLE;
					end else begin
						clr_cnt_r <= clr_cnt_r - 4'h1;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	assign lnk.scan_clk         = scan_clk_r;
	assign lnk.shift_enable     = en_r;
	assign lnk.serial_config_in = dat_r;
	assign lnk.apply_settings   = apl_r;
	assign lnk.pll_async_clear  = clr_r;
	assign prdata               = prdata_r;
	assign pready               = pready_r;
	assign pslverr              = pslverr_r;
endmodule

// file: pll_scan_chain_reconfig_checker.sv
`timescale 1ns/1ps
module pll_scan_chain_reconfig_checker
	import pll_reconfig_pkg::*;
#(
	parameter int NUM_CNT   = NC_LARGE,
	parameter int SCAN_HALF = SCAN_HALF_DEF
) (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic scan_clk,
	input wire logic shift_enable,
	input wire logic serial_config_in,
	input wire logic apply_settings,
	input wire logic pll_async_clear,
	input wire logic reprogram_pending,
	input wire logic serial_config_out
);
	// first rising edge with enable only arms the chain
	localparam int BITS  = chain_len(NUM_CNT) + 1;
	localparam int APPLY = 2 * SCAN_HALF;
	logic            scan_q_r;
	logic [15:0]     rise_cnt_r;
	logic [15:0]     apply_cnt_r;
	wire logic       scan_rise = scan_clk & ~scan_q_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q_r    <= 1'h0;
			rise_cnt_r  <= 16'h0000;
			apply_cnt_r <= 16'h0000;
		end else begin
			scan_q_r    <= scan_clk;
			rise_cnt_r  <= shift_enable ? rise_cnt_r + {15'h0000, scan_rise} : 16'h0000;
			apply_cnt_r <= apply_settings ? apply_cnt_r + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_enable_on_low: assert property ($changed(shift_enable) |-> !scan_clk)
		else $error("enable moved while scan clock high");
	chk_data_on_low: assert property ($changed(serial_config_in) |-> !scan_clk)
		else $error("data moved while scan clock high");
	chk_bit_count: assert property ($fell(shift_enable) |-> rise_cnt_r == 16'(BITS))
		else $error("wrong number of shift edges");
	chk_chain_hold: assert property (!shift_enable |-> $stable(serial_config_out))
		else $error("chain moved without enable");
	chk_apply_width: assert property ($fell(apply_settings) |-> apply_cnt_r == 16'(APPLY))
		else $error("apply not one scan period");
	chk_apply_idle: assert property (apply_settings |-> !shift_enable)
		else $error("apply while shifting");
	chk_pend_follows: assert property ($rose(apply_settings) |-> ##[1:48] reprogram_pending)
		else $error("pending did not rise after apply");
	chk_pend_width: assert property ($rose(reprogram_pending) |-> reprogram_pending[*5])
		else $error("pending too short");
	chk_pend_ends: assert property ($rose(reprogram_pending) |-> ##[5:1000] !reprogram_pending)
		else $error("pending never fell");
	chk_clear_width: assert property ($rose(pll_async_clear) |-> pll_async_clear[*8] ##1 !pll_async_clear)
		else $error("clear width wrong");
	chk_clear_after: assert property ($rose(pll_async_clear) |-> !reprogram_pending)
		else $error("clear before update done");

	cover property ($rose(apply_settings));
	cover property ($fell(reprogram_pending));
	cover property ($rose(pll_async_clear));
endmodule

// file: pll_scan_chain_reconfig_tb.sv
`timescale 1ns/1ps
module pll_scan_chain_reconfig_tb import pll_reconfig_pkg::*;;
	localparam int NC = NC_LARGE;
	localparam int T0 = (NC + 2) * SEG_W;
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] adr;
		logic [31:0]       wd;
		logic [31:0]       exp;
		logic              err;
	} row_t;
	logic                     pclk = 1'h0;
	logic                     presetn = 1'h0;
	logic [ADDR_W-1:0]        paddr = 8'h00;
	logic                     psel = 1'h0;
	logic                     penable = 1'h0;
	logic                     pwrite = 1'h0;
	logic [31:0]              pwdata = 32'h0;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic [NC-1:0]            clk_out;
	logic [NC-1:0][SEG_W-1:0] post_cfg;
	logic [SEG_W-1:0]         pre_cfg;
	logic [SEG_W-1:0]         fb_cfg;
	logic [CP_W-1:0]          cp_current;
	logic                     post_vco_div;
	logic [LFC_W-1:0]         lf_cap;
	logic [LFR_W-1:0]         lf_res;
	logic                     pll_in_reset;
	logic                     seen_rst = 1'h0;
	logic [255:0]             img_a;
	logic [255:0]             img_b;
	logic [31:0]              rd;
	logic                     er;
	int                       n_mismatch = 0;
	int                       n_tests = 0;
	row_t                     rows [8];

	scan_if u_scan_if ();
	pll_scan_chain_reconfig #(.NUM_CNT(NC)) u_pll_scan_chain_reconfig (
		.pclk(pclk), .presetn(presetn), .lnk(u_scan_if), .clk_out(clk_out),
		.post_cfg(post_cfg), .pre_cfg(pre_cfg), .fb_cfg(fb_cfg), .cp_current(cp_current),
		.post_vco_div(post_vco_div), .lf_cap(lf_cap), .lf_res(lf_res),
		.pll_in_reset(pll_in_reset));
	scan_reconfig_ctl #(.NUM_CNT(NC), .SCAN_HALF(SCAN_HALF_DEF)) u_scan_reconfig_ctl (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(u_scan_if));
	pll_scan_chain_reconfig_checker #(.NUM_CNT(NC), .SCAN_HALF(SCAN_HALF_DEF))
		u_pll_scan_chain_reconfig_checker (
		.pclk(pclk), .presetn(presetn), .scan_clk(u_scan_if.scan_clk),
		.shift_enable(u_scan_if.shift_enable), .serial_config_in(u_scan_if.serial_config_in),
		.apply_settings(u_scan_if.apply_settings), .pll_async_clear(u_scan_if.pll_async_clear),
		.reprogram_pending(u_scan_if.reprogram_pending),
		.serial_config_out(u_scan_if.serial_config_out));

	always #20 pclk = ~pclk;
	always @(posedge pclk) if (pll_in_reset === 1'h1) seen_rst <= 1'h1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		for (k = 0; pready !== 1'h1 && k < 50; k++) @(posedge pclk);
		if (k == 50) chk(32'h0, 32'h1, "no bus answer");
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// whole image first, then go; the controller shifts bit 0 first
	task automatic run_pass(input logic [255:0] m, input logic ac);
		for (int k = 0; k < 8; k++) apb(1'h1, OFF_IMG + 8'(4 * k), m[32*k +: 32], rd, er);
		apb(1'h1, OFF_CTRL, {30'h0, ac, 1'h1}, rd, er);
		// go stays high until the next falling scan edge; done from the last pass lingers till then
		rd = 32'h1;
		for (int k = 0; k < 40 && rd[CTRL_GO] !== 1'h0; k++) apb(1'h0, OFF_CTRL, 32'h0, rd, er);
		chk({31'h0, rd[CTRL_GO]}, 32'h0, "go never taken");
	endtask

	task automatic wait_done();
		int k;
		rd = 32'h0;
		for (k = 0; k < 4000 && rd[ST_DONE] !== 1'h1; k++) apb(1'h0, OFF_STAT, 32'h0, rd, er);
		chk({31'h0, rd[ST_DONE]}, 32'h1, "done never set");
		chk({31'h0, rd[ST_BUSY]}, 32'h0, "busy after done");
	endtask

	task automatic check_cfg(input logic [255:0] m);
		for (int i = 0; i < NC; i++) begin
			chk(32'(post_cfg[i]), 32'(m[(NC-1-i)*SEG_W +: SEG_W]), "post seg");
		end
		chk(32'(pre_cfg), 32'(m[NC*SEG_W +: SEG_W]), "pre seg");
		chk(32'(fb_cfg), 32'(m[(NC+1)*SEG_W +: SEG_W]), "fb seg");
		chk(32'({lf_res, lf_cap, 7'h00, post_vco_div, cp_current}), 32'(m[T0 +: TAIL_W]), "tail");
	endtask

	// one pclk is half a vco cycle, so times are in half cycles
	task automatic measure(input int i, input int eh, input int el);
		int k;
		int hc;
		int lc;
		for (k = 0; clk_out[i] !== 1'h0 && k < 99; k++) @(posedge pclk);
		for (k = 0; clk_out[i] !== 1'h1 && k < 99; k++) @(posedge pclk);
		for (hc = 0; clk_out[i] === 1'h1 && hc < 99; hc++) @(posedge pclk);
		for (lc = 0; clk_out[i] === 1'h0 && lc < 99; lc++) @(posedge pclk);
		chk(32'(hc), 32'(eh), "high time");
		chk(32'(lc), 32'(el), "low time");
	endtask

	function automatic logic [255:0] build(input logic v);
		logic [255:0] m;
		m = '0;
		for (int i = 0; i < NC; i++) begin
			m[(NC-1-i)*SEG_W +: SEG_W] = {i == 3 && !v, i == 0, 8'(i < 2 ? 2 : i),
				8'(i < 2 ? 1 : i + 2 + v)};
		end
		m[NC*SEG_W +: SEG_W] = {10'h003, 7'h02, v};
		m[(NC+1)*SEG_W +: SEG_W] = {10'h005, 8'h06};
		m[T0 +: TAIL_W] = {4'h9, v, 2'h3, 7'h00, 1'h1, 3'h5};
		return m;
	endfunction

	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		chk(32'h0, 32'h1, "watchdog expired");
		conclude();
	end

	initial begin
		img_a = build(1'h0);
		img_b = build(1'h1);
		rows = '{'{1'h0, OFF_STAT, 32'h0, 32'h0, 1'h0}, '{1'h1, OFF_CTRL, 32'h2, 32'h0, 1'h0},
			'{1'h0, OFF_CTRL, 32'h0, 32'h2, 1'h0}, '{1'h1, OFF_CTRL, 32'h0, 32'h0, 1'h0},
			'{1'h1, OFF_IMG, 32'hA5A50F0F, 32'h0, 1'h0}, '{1'h0, OFF_IMG, 32'h0, 32'hA5A50F0F, 1'h0},
			'{1'h0, 8'h08, 32'h0, 32'h0, 1'h1}, '{1'h0, 8'h41, 32'h0, 32'h0, 1'h1}};
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk(32'(post_cfg[NC-1]), 32'(SEG_RESET), "reset segment");
		$display("test reset done");
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].adr, rows[i].wd, rd, er);
			chk({31'h0, er}, {31'h0, rows[i].err}, "bus error");
			if (!rows[i].wr) chk(rd, rows[i].exp, "bus read");
		end
		$display("test registers done");
		run_pass(img_a, 1'h0);
		wait_done();
		check_cfg(img_a);
		chk({31'h0, seen_rst}, 32'h0, "clear without auto");
		$display("test first pass done");
		run_pass(img_b, 1'h1);
		apb(1'h1, OFF_IMG, 32'hFFFFFFFF, rd, er);
		wait_done();
		check_cfg(img_b);
		chk({31'h0, seen_rst}, 32'h1, "auto clear");
		apb(1'h0, OFF_IMG, 32'h0, rd, er);
		chk(rd, img_b[31:0], "image write while busy");
		for (int k = 0; k < 8; k++) begin
			apb(1'h0, OFF_RB + 8'(4 * k), 32'h0, rd, er);
			chk(rd & (k == 7 ? 32'h3FF : '1), img_a[32*k +: 32] & (k == 7 ? 32'h3FF : '1), "rb");
		end
		$display("test second pass done");
		run_pass(img_b, 1'h0);
		repeat (300) @(posedge pclk);
		presetn <= 1'h0;
		repeat (4) @(posedge pclk);
		chk(32'(post_cfg[0]), 32'(SEG_RESET), "segment in reset");
		chk({31'h0, u_scan_if.shift_enable}, 32'h0, "enable in reset");
		presetn <= 1'h1;
		run_pass(img_a, 1'h0);
		wait_done();
		check_cfg(img_a);
		measure(0, 3, 3);
		measure(1, 4, 2);
		measure(2, 4, 8);
		measure(3, 1, 1);
		$display("test reset and repeat done");
		conclude();
	end
endmodule
